// >>> rtl/port_b_low_and_cas_pin_mux.sv
// top of the port b low and strobe pin function multiplexer
// assumes peripherals on mclk_i; pad inputs are synchronised here
//
// Notes on behaviour
// - pb7: gpio, clock d, t4 cmp b, pattern
// - pb6: gpio, clock c, t4 cmp a, pattern
// - pb5: gpio, reserved, t4 capcomp b, pattern
// - pb4: gpio, reserved, t4 capcomp a, pattern
// - pb3: gpio, reserved, t3 capcomp b, pattern
// - pb2: gpio, reserved, t3 capcomp a, pattern
// - pb1: gpio, reserved, t2 capcomp b, pattern
// - pb0: gpio, reserved, capcomp, pattern
// - port b fields reset to gpio
// - upper strobe: 01 chip select, 10 column strobe
// - lower strobe: 01 chip select, 10 column strobe
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module port_b_low_and_cas_pin_mux
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // general i/o port side
   input wire logic [7:0] gpio_out_i,
   input wire logic [7:0] gpio_oe_n_i,
   output logic [7:0] gpio_in_o,
   // timer unit side, one bit per pin 0..5
   input wire logic [5:0] timer_out_i,
   input wire logic [5:0] timer_oe_n_i,
   output logic [5:0] timer_capture_o,
   output logic timer_ext_clock_c_o,
   output logic timer_ext_clock_d_o,
   input wire logic timer4_compare_out_a_i,
   input wire logic timer4_compare_out_b_i,
   // timing pattern unit side
   input wire logic [7:0] pattern_out_i,
   // bus controller strobes, active low
   input wire logic chip_select_one_n_i,
   input wire logic chip_select_three_n_i,
   input wire logic col_strobe_high_n_i,
   input wire logic col_strobe_low_n_i,
   // port b low pads, enables active low
   input wire logic [7:0] pb_pad_i,
   output logic [7:0] pb_pad_o,
   output logic [7:0] pb_pad_oe_n_o,
   // strobe pads, active low outputs
   output logic strobe_hi_pad_n_o,
   output logic strobe_lo_pad_n_o
);
   pin_sel_if sel_bus(); // selection fields
   logic [7:0] pad_meta_r; // first sync stage
   logic [7:0] pad_sync_r; // second sync stage
   logic [7:0] pb_out_nxt; // pad data before the flops
   logic [7:0] pb_oe_n_nxt; // pad enable before the flops
   logic [5:0] cap_nxt; // capture inputs before the flops
   logic hi_nxt; // upper strobe before the flop
   logic lo_nxt; // lower strobe before the flop
   logic [7:0] tmr_drive; // timer drive per pin, compare outputs on 6,7
   logic [7:0] tmr_oe_n; // timer enables, compare pins always driven

   // ----------------------------------------
   // register file
   // ----------------------------------------
   pin_mux_regs u_regs
   (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pwdata_i(pwdata_i),
      .prdata_o(prdata_o),
      .pready_o(pready_o),
      .pslverr_o(pslverr_o),
      .sel(sel_bus)
   );

   // ----------------------------------------
   // pad input synchroniser
   // ----------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         pad_meta_r <= 8'h00;
         pad_sync_r <= 8'h00;
      end
      else
      begin
         pad_meta_r <= pb_pad_i;
         pad_sync_r <= pad_meta_r;
      end
   end

   // field of one pin
   function automatic logic [1:0] field_of(input logic [15:0] v, input int idx);
      field_of = v[2*idx +: 2];
   endfunction

   // strobe field decode, reserved codes park the pin high (inactive)
   function automatic logic strobe_pick(input logic [1:0] f, input logic cs_n,
                                        input logic cas_n);
      if (f == pin_mux_pkg::strobe_chip_sel)
         strobe_pick = cs_n;
      else if (f == pin_mux_pkg::strobe_col_sel)
         strobe_pick = cas_n;
      else
         strobe_pick = 1'b1;
   endfunction

   // widened to eight pins so every pin index of the loop stays in range
   assign tmr_drive = {timer4_compare_out_b_i, timer4_compare_out_a_i, timer_out_i};
   assign tmr_oe_n = {2'h0, timer_oe_n_i};

   // ----------------------------------------
   // port b output select
   // ----------------------------------------
   // reserved codes release the pad: undefined use, safest as input
   always_comb
   begin
      pb_out_nxt = 8'h00;
      pb_oe_n_nxt = 8'hFF;
      for (int i = 0; i < 8; i++)
      begin
         case (pin_mux_pkg::pin_sel_t'(field_of(sel_bus.port_b_sel, i)))
            pin_mux_pkg::sel_gpio:
            begin
               pb_out_nxt[i] = gpio_out_i[i];
               pb_oe_n_nxt[i] = gpio_oe_n_i[i];
            end
            pin_mux_pkg::sel_alt1:
            begin
               // clock inputs on pins 6,7, reserved elsewhere
               pb_out_nxt[i] = 1'b0;
               pb_oe_n_nxt[i] = 1'b1;
            end
            pin_mux_pkg::sel_alt2:
            begin
               pb_out_nxt[i] = tmr_drive[i];
               pb_oe_n_nxt[i] = tmr_oe_n[i];
            end
            pin_mux_pkg::sel_pattern:
            begin
               pb_out_nxt[i] = pattern_out_i[i];
               pb_oe_n_nxt[i] = 1'b0;
            end
            default:
            begin
               pb_out_nxt[i] = 1'b0;
               pb_oe_n_nxt[i] = 1'b1;
            end
         endcase
      end
   end

   // capture inputs only see the pad when selected
   always_comb
   begin
      cap_nxt = 6'h00;
      for (int i = 0; i < 6; i++)
         if (field_of(sel_bus.port_b_sel, i) == 2'h2)
            cap_nxt[i] = pad_sync_r[i];
   end

   assign hi_nxt = strobe_pick(sel_bus.strobe_hi_sel, chip_select_one_n_i,
                               col_strobe_high_n_i);
   assign lo_nxt = strobe_pick(sel_bus.strobe_lo_sel, chip_select_three_n_i,
                               col_strobe_low_n_i);

   // ----------------------------------------
   // output flops, one cycle from select to pad
   // ----------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         pb_pad_o <= 8'h00;
         pb_pad_oe_n_o <= 8'hFF;
         strobe_hi_pad_n_o <= 1'b1;
         strobe_lo_pad_n_o <= 1'b1;
      end
      else
      begin
         pb_pad_o <= pb_out_nxt;
         pb_pad_oe_n_o <= pb_oe_n_nxt;
         strobe_hi_pad_n_o <= hi_nxt;
         strobe_lo_pad_n_o <= lo_nxt;
      end
   end

   // peripheral inputs from the synchronised pads
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         gpio_in_o <= 8'h00;
         timer_capture_o <= 6'h00;
         timer_ext_clock_c_o <= 1'b0;
         timer_ext_clock_d_o <= 1'b0;
      end
      else
      begin
         gpio_in_o <= pad_sync_r;
         timer_capture_o <= cap_nxt;
         timer_ext_clock_c_o <= (field_of(sel_bus.port_b_sel, 6) == 2'h1) && pad_sync_r[6];
         timer_ext_clock_d_o <= (field_of(sel_bus.port_b_sel, 7) == 2'h1) && pad_sync_r[7];
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   // ----------------------------------------
   // port b routing checks
   // ----------------------------------------
   // pattern code hands pin 7 to the pattern unit
   pb7_pattern_a: assert property (sel_bus.port_b_sel[15:14] == 2'h3 |=>
      !pb_pad_oe_n_o[7] && pb_pad_o[7] == $past(pattern_out_i[7]))
      else $error("pb7 pattern route wrong");
   // compare code drives pin 7 from compare output b
   pb7_compare_a: assert property (sel_bus.port_b_sel[15:14] == 2'h2 |=>
      !pb_pad_oe_n_o[7] && pb_pad_o[7] == $past(timer4_compare_out_b_i))
      else $error("pb7 compare route wrong");
   // compare code drives pin 6 from compare output a
   pb6_compare_a: assert property (sel_bus.port_b_sel[13:12] == 2'h2 |=>
      pb_pad_o[6] == $past(timer4_compare_out_a_i))
      else $error("pb6 compare route wrong");
   // clock code releases pin 6 and feeds the timer clock
   pb6_clock_a: assert property (sel_bus.port_b_sel[13:12] == 2'h1 |=>
      pb_pad_oe_n_o[6] && timer_ext_clock_c_o == $past(pad_sync_r[6]))
      else $error("pb6 clock input wrong");
   // timer owns the enable of pin 5 on its capcomp code
   pb5_timer_a: assert property (sel_bus.port_b_sel[11:10] == 2'h2 |=>
      pb_pad_oe_n_o[5] == $past(timer_oe_n_i[5]))
      else $error("pb5 timer enable wrong");
   // gpio code passes the port data to pin 4
   pb4_gpio_a: assert property (sel_bus.port_b_sel[9:8] == 2'h0 |=>
      pb_pad_o[4] == $past(gpio_out_i[4]))
      else $error("pb4 gpio route wrong");
   // capture path of pin 3 stays quiet unless selected
   pb3_capture_a: assert property (sel_bus.port_b_sel[7:6] != 2'h2 |=>
      !timer_capture_o[3])
      else $error("pb3 capture leaks");
   // pattern code hands pin 2 to the pattern unit
   pb2_pattern_a: assert property (sel_bus.port_b_sel[5:4] == 2'h3 |=>
      pb_pad_o[2] == $past(pattern_out_i[2]))
      else $error("pb2 pattern route wrong");
   // capcomp code drives pin 1 from the timer
   pb1_timer_a: assert property (sel_bus.port_b_sel[3:2] == 2'h2 |=>
      pb_pad_o[1] == $past(timer_out_i[1]))
      else $error("pb1 timer route wrong");
   // gpio code passes the port enable to pin 0
   pb0_gpio_a: assert property (sel_bus.port_b_sel[1:0] == 2'h0 |=>
      pb_pad_oe_n_o[0] == $past(gpio_oe_n_i[0]))
      else $error("pb0 gpio enable wrong");
   // capcomp code lets the timer see pin 0
   pb0_capture_a: assert property (sel_bus.port_b_sel[1:0] == 2'h2 |=>
      timer_capture_o[0] == $past(pad_sync_r[0]))
      else $error("pb0 capture route wrong");
   // every port b field is gpio right after reset
   reset_gpio_a: assert property ($fell(rst_i) |->
      sel_bus.port_b_sel == 16'h0000)
      else $error("port b not gpio after reset");

   // ----------------------------------------
   // strobe and readback checks
   // ----------------------------------------
   // both strobe pins come out of reset as chip selects
   reset_strobe_a: assert property ($fell(rst_i) |->
      sel_bus.strobe_hi_sel == 2'h1 && sel_bus.strobe_lo_sel == 2'h1)
      else $error("strobe not chip select after reset");
   // column code routes the upper column strobe
   strobe_hi_a: assert property (sel_bus.strobe_hi_sel == 2'h2 |=>
      strobe_hi_pad_n_o == $past(col_strobe_high_n_i))
      else $error("upper strobe wrong");
   // chip select code routes chip select one
   strobe_hi_cs_a: assert property (sel_bus.strobe_hi_sel == 2'h1 |=>
      strobe_hi_pad_n_o == $past(chip_select_one_n_i))
      else $error("upper chip select wrong");
   // chip select code routes chip select three
   strobe_lo_a: assert property (sel_bus.strobe_lo_sel == 2'h1 |=>
      strobe_lo_pad_n_o == $past(chip_select_three_n_i))
      else $error("lower strobe wrong");
   // column code routes the lower column strobe
   strobe_lo_col_a: assert property (sel_bus.strobe_lo_sel == 2'h2 |=>
      strobe_lo_pad_n_o == $past(col_strobe_low_n_i))
      else $error("lower column strobe wrong");
   // unstored low strobe bits 11:0 always read back as ones
   unused_ones_a: assert property (psel_i && !penable_i && !pwrite_i &&
      paddr_i == pin_mux_pkg::strobe_sel_off |=> prdata_o[11:0] == 12'hFFF)
      else $error("unused bits not one");

   // ----------------------------------------
   // cover points
   // ----------------------------------------
   pattern_seen_c: cover property (sel_bus.port_b_sel == 16'hFFFF);
   col_strobe_c: cover property (sel_bus.strobe_hi_sel == 2'h2 && sel_bus.strobe_lo_sel == 2'h2);
   timer_mix_c: cover property (sel_bus.port_b_sel == 16'hAAAA);
   clock_input_c: cover property (sel_bus.port_b_sel[15:12] == 4'h5);
   strobe_mixed_c: cover property (sel_bus.strobe_hi_sel == 2'h1 && sel_bus.strobe_lo_sel == 2'h2);
endmodule
`default_nettype wire

// >>> shared/pin_mux_pkg.sv
// package for the port b low / strobe pin function multiplexer
// assumes a 32-bit apb slave with one aligned word per register
package pin_mux_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] port_b_low_sel_off = 12'h000; // port b low selection
   localparam logic [11:0] strobe_sel_off = 12'h004; // strobe pin selection
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [15:0] port_b_low_sel_rst = 16'h0000; // all pins general i/o
   localparam logic [3:0] strobe_sel_rst = 4'h5; // both fields select chip select
   localparam logic [11:0] strobe_unused_val = 12'hFFF; // unused bits read one
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int strobe_hi_pos = 14; // upper strobe field
   localparam int strobe_lo_pos = 12; // lower strobe field
   localparam int strobe_field_lsb = 12; // lowest stored bit
   // ----------------------------------------
   // selection codes
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      sel_gpio = 2'h0,
      sel_alt1 = 2'h1,
      sel_alt2 = 2'h2,
      sel_pattern = 2'h3
   } pin_sel_t;
   localparam logic [1:0] strobe_chip_sel = 2'h1; // chip select function
   localparam logic [1:0] strobe_col_sel = 2'h2; // column strobe function
endpackage

// >>> shared/pin_sel_if.sv
// carries the pin selection fields from the register file to the mux
// assumes both ends sit on the same clock
`timescale 1ns/10ps
`default_nettype none
interface pin_sel_if;
   logic [15:0] port_b_sel; // two bits per port b pin
   logic [1:0] strobe_hi_sel; // upper strobe pin field
   logic [1:0] strobe_lo_sel; // lower strobe pin field
   modport regs (output port_b_sel, output strobe_hi_sel, output strobe_lo_sel);
   modport mux (input port_b_sel, input strobe_hi_sel, input strobe_lo_sel);
endinterface
`default_nettype wire

// >>> rtl/pin_mux_regs.sv
// apb register file for the two selection registers
// assumes a well-behaved apb master on the same clock
`timescale 1ns/10ps
`default_nettype none
module pin_mux_regs
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // selection fields
   pin_sel_if.regs sel
);
   logic [15:0] port_b_low_select_reg_r; // port b low selection
   logic [3:0] strobe_select_reg_r; // stored strobe fields only
   logic wr_en; // write strobe in access phase
   logic hit_pb; // port b register addressed
   logic hit_st; // strobe register addressed

   // ----------------------------------------
   // decode
   // ----------------------------------------
   assign hit_pb = (paddr_i == pin_mux_pkg::port_b_low_sel_off);
   assign hit_st = (paddr_i == pin_mux_pkg::strobe_sel_off);
   assign wr_en = psel_i && penable_i && pwrite_i;
   // zero wait states keeps the master simple
   assign pready_o = 1'b1;
   // unmapped address flagged in access phase
   assign pslverr_o = psel_i && penable_i && !(hit_pb || hit_st);

   // port b selection register
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         port_b_low_select_reg_r <= pin_mux_pkg::port_b_low_sel_rst;
      else if (wr_en && hit_pb)
         port_b_low_select_reg_r <= pwdata_i[15:0];
   end

   // strobe selection register, low bits are not stored
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         strobe_select_reg_r <= pin_mux_pkg::strobe_sel_rst;
      else if (wr_en && hit_st)
         strobe_select_reg_r <= pwdata_i[pin_mux_pkg::strobe_field_lsb +: 4];
   end

   // read data registered in setup phase
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         prdata_o <= 32'h0000_0000;
      else if (psel_i && !penable_i && !pwrite_i)
      begin
         if (hit_pb)
            prdata_o <= {16'h0000, port_b_low_select_reg_r};
         else if (hit_st)
            prdata_o <= {16'h0000, strobe_select_reg_r,
                         pin_mux_pkg::strobe_unused_val};
         else
            prdata_o <= 32'h0000_0000;
      end
   end

   assign sel.port_b_sel = port_b_low_select_reg_r;
   // stored bits sit at the field positions less the lowest stored bit
   assign sel.strobe_hi_sel = strobe_select_reg_r[pin_mux_pkg::strobe_hi_pos -
                                                  pin_mux_pkg::strobe_field_lsb +: 2];
   assign sel.strobe_lo_sel = strobe_select_reg_r[pin_mux_pkg::strobe_lo_pos -
                                                  pin_mux_pkg::strobe_field_lsb +: 2];
endmodule
`default_nettype wire

// >>> sim/board_model.sv
// board side of the eight port b low pads
// assumes active-low pad enables coming from the mux
`timescale 1ns/10ps
`default_nettype none
module board_model
(
   // clock
   input wire logic mclk_i,
   // pad side of the mux
   input wire logic [7:0] pad_o_i,
   input wire logic [7:0] pad_oe_n_i,
   // board drive control
   input wire logic [7:0] ext_val_i,
   input wire logic ext_en_i,
   // level seen back at the pads
   output logic [7:0] pad_lvl_o
);
   // no pulls on these pads, so a floating pin must not look stable
   logic [7:0] float_r = 8'h5A;
   always @(posedge mclk_i)
   begin
      float_r <= ~float_r;
   end
   // mux drive wins, then board drive, else the floating pattern
   assign pad_lvl_o = (~pad_oe_n_i & pad_o_i) | (pad_oe_n_i & (ext_en_i ? ext_val_i : float_r));
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the port b low and strobe pin mux
// assumes a zero-wait apb slave and one clock
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // ------------------------------
   // signals
   // ------------------------------
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic pready_o, pslverr_o, er;
   logic [7:0] gpio_out_i = 8'h0, gpio_oe_n_i = 8'hFF, gpio_in_o, pattern_out_i = 8'h0;
   logic [5:0] timer_out_i = 6'h0, timer_oe_n_i = 6'h3F, timer_capture_o;
   logic timer_ext_clock_c_o, timer_ext_clock_d_o, cmp_a = 1'b0, cmp_b = 1'b0;
   logic cs1_n = 1'b1, cs3_n = 1'b1, col_strobe_high_n = 1'b1, col_strobe_low_n = 1'b1, sh_n, sl_n;
   logic [7:0] pb_pad_i, pb_pad_o, pb_pad_oe_n_o, ext_val = 8'h0;
   logic ext_en = 1'b0;
   logic [31:0] seed = 32'hAFA3DAE1, r;
   int err_total = 0, tests_run = 0;
   // ------------------------------
   // clock and instances
   // ------------------------------
   initial forever #5 mclk_i = ~mclk_i;
   port_b_low_and_cas_pin_mux u_port_b_low_and_cas_pin_mux
   (
      .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .gpio_out_i(gpio_out_i),
      .gpio_oe_n_i(gpio_oe_n_i), .gpio_in_o(gpio_in_o), .timer_out_i(timer_out_i),
      .timer_oe_n_i(timer_oe_n_i), .timer_capture_o(timer_capture_o),
      .timer_ext_clock_c_o(timer_ext_clock_c_o), .timer_ext_clock_d_o(timer_ext_clock_d_o),
      .timer4_compare_out_a_i(cmp_a), .timer4_compare_out_b_i(cmp_b),
      .pattern_out_i(pattern_out_i), .chip_select_one_n_i(cs1_n),
      .chip_select_three_n_i(cs3_n), .col_strobe_high_n_i(col_strobe_high_n), .col_strobe_low_n_i(col_strobe_low_n),
      .pb_pad_i(pb_pad_i), .pb_pad_o(pb_pad_o), .pb_pad_oe_n_o(pb_pad_oe_n_o),
      .strobe_hi_pad_n_o(sh_n), .strobe_lo_pad_n_o(sl_n)
   );
   board_model u_board_model
   (
      .mclk_i(mclk_i), .pad_o_i(pb_pad_o), .pad_oe_n_i(pb_pad_oe_n_o),
      .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_lvl_o(pb_pad_i)
   );
   // ------------------------------
   // helpers
   // ------------------------------
   // xorshift, so every run sees the same stimulus
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // expected {oe_n, data} of the eight pads for a selection word
   function automatic logic [15:0] exp_pad(input logic [15:0] sel);
      logic [7:0] d, o;
      logic [1:0] c;
      for (int i = 0; i < 8; i++)
      begin
         c = sel[2*i +: 2];
         // code 01 is a clock input or reserved: pad released either way
         o[i] = c == 2'h0 ? gpio_oe_n_i[i] : c == 2'h2 && i < 6 ? timer_oe_n_i[i] : c == 2'h1;
         d[i] = c == 2'h0 ? gpio_out_i[i] : c == 2'h3 ? pattern_out_i[i] :
            c == 2'h1 ? 1'b0 : i < 6 ? timer_out_i[i] : i == 6 ? cmp_a : cmp_b;
      end
      return {o, d};
   endfunction
   // pins 0..5 have no function on code 01, so software never writes it
   function automatic logic [15:0] legal_sel(input logic [15:0] v);
      for (int i = 0; i < 6; i++)
      begin
         if (v[2*i +: 2] == 2'h1)
            v[2*i +: 2] = 2'h0;
      end
      return v;
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer; waits for pready, only the watchdog ends the wait
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do
      begin
         @(posedge mclk_i);
      end
      while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // new random levels on every peripheral and board input
   task automatic drive_rand();
      r = xs();
      {gpio_out_i, gpio_oe_n_i, pattern_out_i, ext_val} <= r;
      r = xs();
      {timer_out_i, timer_oe_n_i, cmp_a, cmp_b, cs1_n, cs3_n, col_strobe_high_n, col_strobe_low_n} <= r[17:0];
      repeat (5) @(posedge mclk_i);
      #1;
   endtask
   // pads and the input paths against one selection word
   task automatic chk_pins(input logic [15:0] sel);
      logic [15:0] e;
      logic [7:0] lvl;
      logic [5:0] cap;
      e = exp_pad(sel);
      lvl = (~e[15:8] & e[7:0]) | (e[15:8] & ext_val);
      for (int i = 0; i < 6; i++) cap[i] = sel[2*i +: 2] == 2'h2 && lvl[i];
      chk("pad enable", {24'h0, pb_pad_oe_n_o}, {24'h0, e[15:8]});
      chk("pad data", {24'h0, pb_pad_o & ~e[15:8]}, {24'h0, e[7:0] & ~e[15:8]});
      chk("gpio in", {24'h0, gpio_in_o}, {24'h0, lvl});
      chk("capture", {26'h0, timer_capture_o}, {26'h0, cap});
      chk("clock c", {31'h0, timer_ext_clock_c_o}, {31'h0, sel[13:12] == 2'h1 && lvl[6]});
      chk("clock d", {31'h0, timer_ext_clock_d_o}, {31'h0, sel[15:14] == 2'h1 && lvl[7]});
   endtask
   task automatic chk_reset();
      apb(1'b0, pin_mux_pkg::port_b_low_sel_off, 32'h0);
      chk("port b reset", rd, 32'h0000_0000);
      apb(1'b0, pin_mux_pkg::strobe_sel_off, 32'h0);
      chk("strobe reset", rd, 32'h0000_5FFF);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ------------------------------
   // watchdog and main sequence
   // ------------------------------
   initial
   begin
      #200000;
      err_total++;
      print_verdict();
   end
   initial
   begin
      logic [1:0] hi, lo;
      logic [15:0] sel;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      chk_reset();
      ext_en <= 1'b1;
      drive_rand();
      chk_pins(16'h0000);
      // unmapped word: refused, nothing stored
      apb(1'b1, 12'h008, 32'hFFFF_FFFF);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped read", rd, 32'h0);
      chk("unmapped error", {31'h0, er}, 32'h1);
      $display("register test done");
      // each code on all pins first (01 on pins 6,7 only), then mixed random fields
      for (int n = 0; n < 28; n++)
      begin
         r = xs();
         sel = legal_sel(n < 4 ? {8{n[1:0]}} : r[15:0]);
         apb(1'b1, pin_mux_pkg::port_b_low_sel_off, {r[31:16], sel});
         apb(1'b0, pin_mux_pkg::port_b_low_sel_off, 32'h0);
         chk("port b readback", rd, {16'h0, sel});
         drive_rand();
         chk_pins(sel);
      end
      $display("port b test done");
      // strobe pins: each legal code pair, junk in the unused bits
      for (int n = 0; n < 4; n++)
      begin
         hi = n[0] ? 2'h2 : 2'h1;
         lo = n[1] ? 2'h2 : 2'h1;
         r = xs();
         apb(1'b1, pin_mux_pkg::strobe_sel_off, {r[31:16], hi, lo, r[11:0]});
         apb(1'b0, pin_mux_pkg::strobe_sel_off, 32'h0);
         chk("strobe readback", rd, {16'h0, hi, lo, 12'hFFF});
         drive_rand();
         chk("strobe hi", {31'h0, sh_n}, {31'h0, hi == 2'h1 ? cs1_n : col_strobe_high_n});
         chk("strobe lo", {31'h0, sl_n}, {31'h0, lo == 2'h1 ? cs3_n : col_strobe_low_n});
      end
      $display("strobe test done");
      // reset again in mid-run: selections must fall back
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      chk_reset();
      drive_rand();
      chk_pins(16'h0000);
      chk("reset strobe hi", {31'h0, sh_n}, {31'h0, cs1_n});
      chk("reset strobe lo", {31'h0, sl_n}, {31'h0, cs3_n});
      $display("second reset test done");
      print_verdict();
   end
endmodule
`default_nettype wire
